// ==== hw/cias_accept.sv ====
`timescale 1ns/100ps
`include "cias_cfg.svh"
module cias_accept
	import cias_pkg::*;
#(
	parameter int NSRC = `CIAS_NUM_SRC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [NSRC-1:0] i_src_req,
	input wire logic [NSRC-1:0] i_req_clr,
	input wire logic i_lvl_wr,
	input wire logic [2:0] i_lvl_idx,
	input wire logic [2:0] i_lvl_data,
	input wire logic i_flg_wr,
	input wire logic [15:0] i_flg_data,
	input wire cias_special_t i_special,
	input wire logic i_insn_done,
	input wire logic i_insn_suspendable,
	input wire logic i_soft_int,
	input wire logic [5:0] i_soft_num,
	input wire logic i_bus_8bit,
	input wire logic i_vec_odd,
	input wire logic i_sp_odd,
	output logic o_irq_pending,
	output logic o_suspend,
	output logic o_entry,
	output logic o_info_rd,
	output logic [19:0] o_info_addr,
	output cias_info_t o_info,
	output logic o_push_valid,
	output logic o_push_is_pc,
	output logic [15:0] o_push_data,
	output logic o_fetch_start,
	output logic [15:0] o_flg,
	output logic [NSRC-1:0] o_req,
	output logic [3*NSRC-1:0] o_lvl
);
	cias_regs_t r_q, r_d;
	logic [NSRC-1:0] src_s1_q, src_s2_q, src_s3_q;
	logic [2:0] best_lvl;
	logic [4:0] best_idx;
	logic best_v;
	cias_class_t win_cls;

	function automatic logic [2:0] src_lvl(input logic [23:0] l, input int i);
		src_lvl = l[3*i +: 3];
	endfunction : src_lvl

	function automatic logic [4:0] seq_len(input logic b8, input logic vo,
		input logic so, input cias_class_t c);
		logic [4:0] n;
		n = b8 ? `CIAS_SEQ_BYTE : (`CIAS_SEQ_BASE + {4'h0, vo} + {4'h0, so});
		if (c == CL_DEBUG) begin
			n = n + `CIAS_ADD_DBG;
		end else if (c == CL_STEP || c == CL_MATCH) begin
			n = n + `CIAS_ADD_STEP;
		end
		seq_len = n;
	endfunction : seq_len

	// Pins are asynchronous, so they pass two flops before the edge detect.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			src_s1_q <= '0;
			src_s2_q <= '0;
			src_s3_q <= '0;
		end else begin
			src_s1_q <= i_src_req;
			src_s2_q <= src_s1_q;
			src_s3_q <= src_s2_q;
		end
	end

	// Lower index wins a level tie, giving a fixed hardware order.
	always_comb begin
		best_lvl = `CIAS_LVL_OFF;
		best_idx = 5'h00;
		best_v = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (r_q.req[i] && src_lvl(r_q.lvl, i) != `CIAS_LVL_OFF &&
				src_lvl(r_q.lvl, i) >
				r_q.processor_flag_register[`CIAS_FLG_IPL_LO +: 3] &&
				src_lvl(r_q.lvl, i) >= best_lvl) begin
				best_lvl = src_lvl(r_q.lvl, i);
				best_idx = 5'(i);
				best_v = 1'b1;
			end
		end
	end

	always_comb begin
		if (i_special.reset) begin
			win_cls = CL_RESET;
		end else if (i_special.nmi) begin
			win_cls = CL_NMI;
		end else if (i_special.debug) begin
			win_cls = CL_DEBUG;
		end else if (i_special.wdog) begin
			win_cls = CL_WDOG;
		end else if (best_v && r_q.processor_flag_register[`CIAS_FLG_I]) begin
			win_cls = CL_PERIPH;
		end else if (i_special.step) begin
			win_cls = CL_STEP;
		end else if (i_special.match) begin
			win_cls = CL_MATCH;
		end else begin
			win_cls = CL_NONE;
		end
	end

	always_comb begin
		r_d = r_q;
		r_d.entry = 1'b0;
		r_d.push_v = 1'b0;
		// Set wins over clear so a request in the clear cycle is kept.
		r_d.req = (r_q.req & ~i_req_clr) | (src_s2_q & ~src_s3_q);
		if (i_lvl_wr) begin
			r_d.lvl[3*i_lvl_idx +: 3] = i_lvl_data;
		end
		if (i_flg_wr) begin
			r_d.processor_flag_register = i_flg_data;
		end
		if (i_soft_int && i_soft_num >= `CIAS_SOFT_LO) begin
			r_d.processor_flag_register[`CIAS_FLG_I] = 1'b0;
			r_d.processor_flag_register[`CIAS_FLG_D] = 1'b0;
		end
		case (r_q.st)
			ST_IDLE: begin
				// Clearing the count keeps the fetch strobe to one cycle.
				r_d.cnt = 5'h00;
				if (win_cls != CL_NONE &&
					(i_insn_done || i_insn_suspendable)) begin
					r_d.st = ST_INFO;
					r_d.entry = 1'b1;
					r_d.cnt = 5'h01;
					r_d.len = seq_len(i_bus_8bit, i_vec_odd, i_sp_odd, win_cls);
					r_d.info.cls = win_cls;
					r_d.info.number = best_idx;
					r_d.info.level = best_lvl;
				end
			end
			ST_INFO: begin
				if (r_q.info.cls == CL_PERIPH) begin
					r_d.req[r_q.info.number[2:0]] = 1'b0;
				end
				r_d.tmp_flg = r_q.processor_flag_register;
				r_d.st = ST_SAVE;
			end
			ST_SAVE: begin
				r_d.processor_flag_register[`CIAS_FLG_I] = 1'b0;
				r_d.processor_flag_register[`CIAS_FLG_D] = 1'b0;
				r_d.processor_flag_register[`CIAS_FLG_U] = 1'b0;
				r_d.st = ST_PUSHF;
			end
			ST_PUSHF: begin
				r_d.push = r_q.tmp_flg;
				r_d.push_v = 1'b1;
				r_d.push_pc = 1'b0;
				r_d.st = ST_PUSHPC;
			end
			ST_PUSHPC: begin
				r_d.push_v = 1'b1;
				r_d.push_pc = 1'b1;
				r_d.st = ST_DONE;
			end
			ST_DONE: begin
				if (r_q.cnt >= r_q.len - 5'h01) begin
					case (r_q.info.cls)
						CL_PERIPH: r_d.processor_flag_register[`CIAS_FLG_IPL_LO +: 3] = r_q.info.level;
						CL_NMI, CL_WDOG:
							r_d.processor_flag_register[`CIAS_FLG_IPL_LO +: 3] = `CIAS_LVL_MAX;
						CL_RESET:
							r_d.processor_flag_register[`CIAS_FLG_IPL_LO +: 3] = `CIAS_LVL_OFF;
						default: r_d.processor_flag_register = r_d.processor_flag_register;
					endcase
					r_d.st = ST_IDLE;
				end
			end
			default: r_d.st = ST_IDLE;
		endcase
		if (r_q.st != ST_IDLE) begin
			r_d.cnt = r_q.cnt + 5'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			r_q <= '0;
			r_q.st <= ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	assign o_irq_pending = (win_cls != CL_NONE);
	assign o_suspend = (r_q.st == ST_IDLE) && (win_cls != CL_NONE) &&
		i_insn_suspendable;
	assign o_entry = r_q.entry;
	assign o_info_rd = (r_q.st == ST_INFO);
	assign o_info_addr = `CIAS_INFO_ADDR;
	assign o_info = r_q.info;
	assign o_push_valid = r_q.push_v;
	assign o_push_is_pc = r_q.push_pc;
	assign o_push_data = r_q.push;
	// Fetch starts after the threshold update lands.
	assign o_fetch_start = (r_q.st == ST_IDLE) && (r_q.cnt != 5'h00) &&
		(r_q.cnt == r_q.len);
	assign o_flg = r_q.processor_flag_register;
	assign o_req = r_q.req;
	assign o_lvl = r_q.lvl;

	property p_no_accept_disabled;
		@(posedge i_clk) disable iff (!i_reset_n)
		(r_q.entry && r_q.info.cls == CL_PERIPH) |->
		$past(r_q.processor_flag_register[`CIAS_FLG_I]) && r_q.info.level != 3'h0 &&
		r_q.info.level > $past(r_q.processor_flag_register[14:12]);
	endproperty
	a_no_accept_disabled: assert property (p_no_accept_disabled)
		else $error("peripheral accepted while not eligible");

	property p_req_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		(r_q.st == ST_INFO && r_q.info.cls == CL_PERIPH && !src_s2_q[0]) |=>
		(r_q.info.number != 5'h00 || !r_q.req[0]);
	endproperty
	a_req_clear: assert property (p_req_clear)
		else $error("request bit not cleared by info read");

	property p_flags_cleared;
		@(posedge i_clk) disable iff (!i_reset_n)
		(r_q.st == ST_SAVE && !i_flg_wr) |=>
		!r_q.processor_flag_register[`CIAS_FLG_I] && !r_q.processor_flag_register[`CIAS_FLG_U];
	endproperty
	a_flags_cleared: assert property (p_flags_cleared)
		else $error("flags not cleared");

	property p_push_order;
		@(posedge i_clk) disable iff (!i_reset_n)
		(r_q.push_v && !r_q.push_pc) |=> (r_q.push_v && r_q.push_pc);
	endproperty
	a_push_order: assert property (p_push_order)
		else $error("program counter push did not follow flags");

	property p_seq_len;
		@(posedge i_clk) disable iff (!i_reset_n)
		(r_q.entry && !i_flg_wr) |-> r_q.len >= 5'd18 && r_q.len <= 5'd22;
	endproperty
	a_seq_len: assert property (p_seq_len)
		else $error("sequence length out of range");

	property p_seq_done;
		@(posedge i_clk) disable iff (!i_reset_n)
		r_q.entry |-> ##[17:21] (r_q.st == ST_IDLE);
	endproperty
	a_seq_done: assert property (p_seq_done)
		else $error("sequence did not finish in time");

	property p_nmi_ipl;
		@(posedge i_clk) disable iff (!i_reset_n)
		(r_q.st == ST_DONE && r_d.st == ST_IDLE && r_q.info.cls == CL_NMI
		&& !i_flg_wr) |=> r_q.processor_flag_register[14:12] == 3'h7;
	endproperty
	a_nmi_ipl: assert property (p_nmi_ipl)
		else $error("threshold not seven after NMI");

	property p_reset_enable;
		@(posedge i_clk) !i_reset_n |=> !r_q.processor_flag_register[`CIAS_FLG_I];
	endproperty
	a_reset_enable: assert property (p_reset_enable)
		else $error("enable flag set after reset");
endmodule : cias_accept

// ==== hw/cias_cfg.svh ====
// Behaviour
// - Level zero disables; one to seven ascend.
// - Eligible only when level exceeds threshold.
// - Accept needs enable, request and level.
// - Three-bit threshold; all ones blocks all.
// - Enable, requests, levels, threshold stored independently.
// - Use read-modify-write instructions to avoid lost requests.
// - Resolve at instruction end, start next cycle.
// - String and accumulate instructions are suspended.
// - Info read first; clears accepted request.
// - Save flags into hidden temporary register.
// - Clear enable, debug, stack flags; soft 32-63 keep stack.
// - Push saved flags, then program counter.
// - Load accepted level into threshold, then fetch.
// - Sequence 18/19/20 cycles; 8-bit bus 20.
// - Debugger adds two cycles; match/step add one.
// - Instruction wait never exceeds thirty cycles.
// - Watchdog/NMI threshold 7, reset 0, else unchanged.
// - Hardware sets request; software may only clear.
// - Global enable is zero after reset.
// - Highest level wins; ties by fixed order.
// - Class order reset, NMI, debugger, watchdog, peripheral, step, match.
`ifndef CIAS_CFG_SVH
`define CIAS_CFG_SVH
`define CIAS_NUM_SRC 8
`define CIAS_LVL_W 3
`define CIAS_LVL_OFF 3'h0
`define CIAS_LVL_MAX 3'h7
`define CIAS_INFO_ADDR 20'h00000
`define CIAS_SEQ_BASE 5'h12
`define CIAS_SEQ_BYTE 5'h14
`define CIAS_ADD_DBG 5'h02
`define CIAS_ADD_STEP 5'h01
`define CIAS_WAIT_MAX 5'h1E
`define CIAS_SOFT_LO 6'h20
`define CIAS_FLG_I 6
`define CIAS_FLG_D 5
`define CIAS_FLG_U 7
`define CIAS_FLG_IPL_LO 12
`endif

// ==== hw/cias_pkg.sv ====
package cias_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_INFO = 6'h02,
		ST_SAVE = 6'h04,
		ST_PUSHF = 6'h08,
		ST_PUSHPC = 6'h10,
		ST_DONE = 6'h20
	} cias_state_t;
	typedef enum logic [2:0] {
		CL_NONE = 3'h0,
		CL_RESET = 3'h1,
		CL_NMI = 3'h2,
		CL_DEBUG = 3'h3,
		CL_WDOG = 3'h4,
		CL_PERIPH = 3'h5,
		CL_STEP = 3'h6,
		CL_MATCH = 3'h7
	} cias_class_t;
	typedef struct packed {
		logic reset;
		logic nmi;
		logic debug;
		logic wdog;
		logic step;
		logic match;
	} cias_special_t;
	typedef struct packed {
		logic [4:0] number;
		logic [2:0] level;
		cias_class_t cls;
	} cias_info_t;
	typedef struct packed {
		cias_state_t st;
		logic [4:0] cnt;
		logic [4:0] len;
		logic [15:0] tmp_flg;
		logic [15:0] processor_flag_register;
		logic [7:0] req;
		logic [23:0] lvl;
		cias_info_t info;
		logic entry;
		logic [15:0] push;
		logic push_v;
		logic push_pc;
	} cias_regs_t;
endpackage : cias_pkg

// ==== test/cias_core_model.sv ====
`timescale 1ns/100ps
// Stands in for the instruction pipeline. It reports a boundary every fourth
// cycle and stalls while an entry sequence runs, so no second accept overlaps.
module cias_core_model (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_entry,
	input wire logic i_fetch,
	output logic o_insn_done,
	output logic o_suspendable
);
	logic in_seq;
	logic [1:0] cnt;
	initial begin
		in_seq = 1'b0;
		cnt = 2'h0;
		o_insn_done = 1'b0;
		o_suspendable = 1'b0;
	end
	always @(posedge i_clk) begin
		if (i_entry)
			in_seq <= 1'b1;
		else if (i_fetch)
			in_seq <= 1'b0;
	end
	always @(negedge i_clk) begin
		cnt <= cnt + 2'h1;
		o_insn_done <= i_run && !in_seq && !i_entry && cnt == 2'h3;
	end
endmodule : cias_core_model

// ==== test/test_cpu_interrupt_accept_sequencer.sv ====
`timescale 1ns/100ps
module test_cpu_interrupt_accept_sequencer;
	import cias_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [7:0] i_src_req = 8'h00;
	logic [7:0] i_req_clr = 8'h00;
	logic i_lvl_wr = 1'b0;
	logic [2:0] i_lvl_idx = 3'h0;
	logic [2:0] i_lvl_data = 3'h0;
	logic i_flg_wr = 1'b0;
	logic [15:0] i_flg_data = 16'h0000;
	cias_special_t i_special = '0;
	logic i_bus_8bit = 1'b0;
	logic i_vec_odd = 1'b0;
	logic i_sp_odd = 1'b0;
	logic run = 1'b0;
	logic insn_done, susp, pend, entry, fetch, pv, ppc;
	logic [15:0] processor_flag_register;
	logic [7:0] req;
	logic [23:0] lvl;
	int errors = 0;
	int n_checks = 0;
	always #20 i_clk = ~i_clk;
	cias_core_model core (.i_clk(i_clk), .i_run(run), .i_entry(entry),
		.i_fetch(fetch), .o_insn_done(insn_done), .o_suspendable(susp));
	cias_accept dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_src_req(i_src_req), .i_req_clr(i_req_clr), .i_lvl_wr(i_lvl_wr),
		.i_lvl_idx(i_lvl_idx), .i_lvl_data(i_lvl_data), .i_flg_wr(i_flg_wr),
		.i_flg_data(i_flg_data), .i_special(i_special),
		.i_insn_done(insn_done), .i_insn_suspendable(susp),
		.i_soft_int(1'b0), .i_soft_num(6'h00), .i_bus_8bit(i_bus_8bit),
		.i_vec_odd(i_vec_odd), .i_sp_odd(i_sp_odd), .o_irq_pending(pend),
		.o_suspend(), .o_entry(entry), .o_info_rd(), .o_info_addr(),
		.o_info(), .o_push_valid(pv), .o_push_is_pc(ppc), .o_push_data(),
		.o_fetch_start(fetch), .o_flg(processor_flag_register), .o_req(req), .o_lvl(lvl));
	task end_of_test;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr_lvl(input logic [2:0] idx, input logic [2:0] val);
		@(negedge i_clk) begin
			i_lvl_wr = 1'b1;
			i_lvl_idx = idx;
			i_lvl_data = val;
		end
		@(negedge i_clk) i_lvl_wr = 1'b0;
	endtask : wr_lvl
	// Two idle cycles after every write keep prefetch from racing the enable.
	task wr_flg(input logic [15:0] val);
		@(negedge i_clk) begin
			i_flg_wr = 1'b1;
			i_flg_data = val;
		end
		@(negedge i_clk) i_flg_wr = 1'b0;
		repeat (2) @(negedge i_clk);
	endtask : wr_flg
	// The request pins pass a two-flop synchroniser, hence the long wait.
	task raise(input logic [7:0] m);
		@(negedge i_clk) i_src_req = m;
		repeat (5) @(negedge i_clk);
		i_src_req = 8'h00;
	endtask : raise
	task seq(input int len);
		int n, k, pc_first;
		n = 0;
		pc_first = -1;
		run = 1'b1;
		while (!entry && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		chk(entry, 1'b1);
		chk(n <= 30, 1'b1);
		i_special = '0;
		run = 1'b0;
		k = 1;
		while (!fetch && k < 40) begin
			if (pv && pc_first < 0)
				pc_first = ppc;
			@(negedge i_clk);
			k++;
		end
		chk(k, len);
		chk(pc_first, 0);
		chk(processor_flag_register[6], 1'b0);
	endtask : seq
	initial begin
		#(40 * 3000);
		errors++;
		end_of_test;
	end
	initial begin
		repeat (5) @(negedge i_clk);
		i_reset_n = 1'b1;
		@(negedge i_clk);
		chk(processor_flag_register[6], 1'b0);
		chk(req, 8'h00);
		wr_lvl(3'h2, 3'h3);
		wr_lvl(3'h0, 3'h3);
		wr_flg(16'h3040);
		raise(8'h05);
		chk(req, 8'h05);
		chk(pend, 1'b0);
		wr_flg(16'h2040);
		chk(pend, 1'b1);
		wr_flg(16'h2000);
		chk(pend, 1'b0);
		chk(lvl[8:6], 3'h3);
		chk(req, 8'h05);
		wr_lvl(3'h2, 3'h7);
		wr_lvl(3'h0, 3'h0);
		wr_flg(16'h7040);
		chk(pend, 1'b0);
		wr_flg(16'h0040);
		chk(pend, 1'b1);
		wr_lvl(3'h2, 3'h3);
		wr_lvl(3'h0, 3'h3);
		wr_flg(16'h2040);
		seq(18);
		chk(req, 8'h04);
		chk(processor_flag_register[14:12], 3'h3);
		i_vec_odd = 1'b1;
		wr_flg(16'h2040);
		seq(19);
		chk(req, 8'h00);
		i_bus_8bit = 1'b1;
		raise(8'h04);
		wr_flg(16'h0040);
		seq(20);
		i_bus_8bit = 1'b0;
		i_vec_odd = 1'b0;
		i_special.wdog = 1'b1;
		seq(18);
		chk(processor_flag_register[14:12], 3'h7);
		wr_flg(16'h2000);
		i_special.step = 1'b1;
		seq(19);
		chk(processor_flag_register[14:12], 3'h2);
		i_special.debug = 1'b1;
		seq(20);
		i_special.nmi = 1'b1;
		seq(18);
		chk(processor_flag_register[14:12], 3'h7);
		i_special.reset = 1'b1;
		seq(18);
		chk(processor_flag_register[14:12], 3'h0);
		end_of_test;
	end
endmodule : test_cpu_interrupt_accept_sequencer
